// ===== rtl/traverse_pkg.sv
// constants, types and register map for the traverse frequency modulator
package traverse_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned TERMINALS = 8;
  localparam logic [7:0] REG_APP_MODE = 8'h00;
  localparam logic [7:0] REG_AMPLITUDE = 8'h04;
  localparam logic [7:0] REG_SCRAMBLE = 8'h08;
  localparam logic [7:0] REG_ACC_TIME = 8'h0C;
  localparam logic [7:0] REG_DEC_TIME = 8'h10;
  localparam logic [7:0] REG_HI_OFFSET = 8'h14;
  localparam logic [7:0] REG_LO_OFFSET = 8'h18;
  localparam logic [7:0] REG_TERM_FUNC_LO = 8'h1C;
  localparam logic [7:0] REG_TERM_FUNC_HI = 8'h20;
  localparam logic [7:0] REG_FREQ_REF = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [2:0] APP_NONE = 3'h0;
  localparam logic [2:0] APP_TRAVERSE = 3'h1;
  localparam logic [2:0] APP_MODE_MAX = 3'h4;
  localparam logic [12:0] AMPLITUDE_MAX = 13'h00C8;
  localparam logic [12:0] SCRAMBLE_MAX = 13'h01F4;
  localparam logic [12:0] OFFSET_MAX = 13'h00C8;
  localparam logic [12:0] PCT_MIN = 13'h0000;
  localparam logic [9:0] PCT_RST = 10'h000;
  localparam logic [12:0] TIME_MIN = 13'h0001;
  localparam logic [12:0] TIME_MAX = 13'h1770;
  localparam logic [12:0] ACC_TIME_RST = 13'h0014;
  localparam logic [12:0] DEC_TIME_RST = 13'h001E;
  localparam logic [15:0] FREQ_REF_RST = 16'h0000;
  localparam logic [7:0] FUNC_NONE = 8'h00;
  localparam logic [7:0] FUNC_OFFSET_LO = 8'h1B;
  localparam logic [7:0] FUNC_OFFSET_HI = 8'h1C;
  localparam logic [25:0] PERMILLE = 26'h00003E8;
  localparam int unsigned FUNC_W = 8;
  localparam int unsigned STAT_RISE_BIT = 16;
  localparam int unsigned STAT_FALL_BIT = 17;
  localparam int unsigned STAT_HI_BIT = 18;
  localparam int unsigned STAT_LO_BIT = 19;
  localparam logic signed [18:0] FREQ_CEIL = 19'sh0FFFF;
  localparam logic signed [18:0] FREQ_FLOOR = 19'sh00000;
  localparam int unsigned SETTING_STEP_MS = 100;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TENTH_CYCLES = SETTING_STEP_MS * CLK_MHZ * 1000;

  typedef enum logic [1:0] {ST_BYPASS, ST_RISE, ST_FALL} trav_state_e;

  typedef struct packed {
    logic [2:0] app_mode;
    logic [9:0] amplitude;
    logic [9:0] scramble;
    logic [12:0] acc_time;
    logic [12:0] dec_time;
    logic [9:0] hi_offset;
    logic [9:0] lo_offset;
    logic [15:0] freq_ref;
  } settings_s;
endpackage

// ===== rtl/ramp_stepper.sv
// rate generator: spreads span unit steps evenly over a ramp time
`timescale 1ns/1ps
module ramp_stepper
  import traverse_pkg::*;
#(
  parameter int unsigned TENTH_CYCLES_P = TENTH_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic restart,
  input wire logic [17:0] span,
  input wire logic [12:0] time_tenths,
  output logic step
);
  logic [39:0] period;
  logic [39:0] sum;
  logic [39:0] acc_q;
  logic [39:0] acc_d;
  logic step_d;
  logic step_q;

  always_comb
  begin
    period = 40'(time_tenths) * 40'(TENTH_CYCLES_P);
    sum = acc_q + 40'(span);
    acc_d = sum;
    step_d = 1'b0;
    if (!run || restart)
    begin
      acc_d = '0;
    end
    else if (sum >= period)
    begin
      acc_d = sum - period;
      step_d = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      acc_q <= '0;
      step_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      step_q <= step_d;
    end
  end

  assign step = step_q;
endmodule

// ===== rtl/traverse_modulator.sv
// traverse frequency modulator: register file, offset terminals and swing ramp
`timescale 1ns/1ps
// Function
// - swing amplitude is 0 to 20 percent of frequency reference, default 0
// - on each fall start, jump down by 0 to 50 percent of swing
// - rise and fall ramps use own times, 0.1 to 600 s, defaults 2 and 3
// - in traverse mode only, terminal with function 27 active subtracts low offset percent of reference
module traverse_modulator
  import traverse_pkg::*;
#(
  parameter int unsigned TENTH_CYCLES_P = TENTH_CYCLES
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [7:0] TERM_IN,
  output logic [15:0] OUT_FREQ,
  output logic TRAVERSE_ACTIVE
);
  settings_s cfg_q, cfg_d;
  logic [7:0] func_q [TERMINALS], func_d [TERMINALS];
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] term_s1_q, term_s2_q;
  logic [7:0] hi_match, lo_match;
  logic hi_active, lo_active;
  trav_state_e state_q, state_d;
  logic signed [18:0] dev_q, dev_d;
  logic [15:0] out_q, out_d;
  logic active_q, active_d;
  logic [25:0] amp_prod, scr_prod, hi_prod, lo_prod;
  logic [25:0] amp_full, scr_full, hi_full, lo_full;
  logic signed [18:0] amp_s, scr_s, hi_s, lo_s, center_s, sum_s;
  logic step, traverse;

  function automatic logic [12:0] clamp(input logic [31:0] v, input logic [12:0] lo,
                                        input logic [12:0] hi);
    logic [12:0] r;
    r = v[12:0];
    if (v > 32'(hi))
    begin
      r = hi;
    end
    else if (v < 32'(lo))
    begin
      r = lo;
    end
    return r;
  endfunction

  // offset terminal decode, one matcher per input terminal
  for (genvar i = 0; i < TERMINALS; i++)
  begin : g_term
    assign hi_match[i] = term_s2_q[i] && (func_q[i] == FUNC_OFFSET_HI);
    assign lo_match[i] = term_s2_q[i] && (func_q[i] == FUNC_OFFSET_LO);
  end
  assign hi_active = |hi_match;
  assign lo_active = |lo_match;

  // register file
  always_comb
  begin
    cfg_d = cfg_q;
    func_d = func_q;
    rdata_d = '0;
    if (WR)
    begin
      unique case (ADDR)
        REG_APP_MODE: cfg_d.app_mode = 3'(clamp(WDATA, PCT_MIN, 13'(APP_MODE_MAX)));
        REG_AMPLITUDE: cfg_d.amplitude = 10'(clamp(WDATA, PCT_MIN, AMPLITUDE_MAX));
        REG_SCRAMBLE: cfg_d.scramble = 10'(clamp(WDATA, PCT_MIN, SCRAMBLE_MAX));
        REG_ACC_TIME: cfg_d.acc_time = clamp(WDATA, TIME_MIN, TIME_MAX);
        REG_DEC_TIME: cfg_d.dec_time = clamp(WDATA, TIME_MIN, TIME_MAX);
        REG_HI_OFFSET: cfg_d.hi_offset = 10'(clamp(WDATA, PCT_MIN, OFFSET_MAX));
        REG_LO_OFFSET: cfg_d.lo_offset = 10'(clamp(WDATA, PCT_MIN, OFFSET_MAX));
        REG_TERM_FUNC_LO:
          for (int t = 0; t < TERMINALS / 2; t++)
            func_d[t] = WDATA[t*FUNC_W +: FUNC_W];
        REG_TERM_FUNC_HI:
          for (int t = 0; t < TERMINALS / 2; t++)
            func_d[t + TERMINALS / 2] = WDATA[t*FUNC_W +: FUNC_W];
        REG_FREQ_REF: cfg_d.freq_ref = WDATA[15:0];
        default: ;
      endcase
    end
    if (RD)
    begin
      unique case (ADDR)
        REG_APP_MODE: rdata_d = 32'(cfg_q.app_mode);
        REG_AMPLITUDE: rdata_d = 32'(cfg_q.amplitude);
        REG_SCRAMBLE: rdata_d = 32'(cfg_q.scramble);
        REG_ACC_TIME: rdata_d = 32'(cfg_q.acc_time);
        REG_DEC_TIME: rdata_d = 32'(cfg_q.dec_time);
        REG_HI_OFFSET: rdata_d = 32'(cfg_q.hi_offset);
        REG_LO_OFFSET: rdata_d = 32'(cfg_q.lo_offset);
        REG_TERM_FUNC_LO: rdata_d = {func_q[3], func_q[2], func_q[1], func_q[0]};
        REG_TERM_FUNC_HI: rdata_d = {func_q[7], func_q[6], func_q[5], func_q[4]};
        REG_FREQ_REF: rdata_d = 32'(cfg_q.freq_ref);
        REG_STATUS:
        begin
          rdata_d[15:0] = out_q;
          rdata_d[STAT_RISE_BIT] = (state_q == ST_RISE);
          rdata_d[STAT_FALL_BIT] = (state_q == ST_FALL);
          rdata_d[STAT_HI_BIT] = hi_active;
          rdata_d[STAT_LO_BIT] = lo_active;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      cfg_q.app_mode <= APP_NONE;
      cfg_q.amplitude <= PCT_RST;
      cfg_q.scramble <= PCT_RST;
      cfg_q.acc_time <= ACC_TIME_RST;
      cfg_q.dec_time <= DEC_TIME_RST;
      cfg_q.hi_offset <= PCT_RST;
      cfg_q.lo_offset <= PCT_RST;
      cfg_q.freq_ref <= FREQ_REF_RST;
      for (int t = 0; t < TERMINALS; t++)
        func_q[t] <= FUNC_NONE;
      rdata_q <= '0;
      term_s1_q <= '0;
      term_s2_q <= '0;
    end
    else
    begin
      cfg_q <= cfg_d;
      func_q <= func_d;
      rdata_q <= rdata_d;
      term_s1_q <= TERM_IN;
      term_s2_q <= term_s1_q;
    end
  end

  // swing, scramble and offset sizes
  always_comb
  begin
    amp_prod = 26'(cfg_q.freq_ref) * 26'(cfg_q.amplitude);
    amp_full = amp_prod / PERMILLE;
    amp_s = signed'(19'(amp_full[15:0]));
    scr_prod = 26'(amp_full[15:0]) * 26'(cfg_q.scramble);
    scr_full = scr_prod / PERMILLE;
    scr_s = signed'(19'(scr_full[15:0]));
    hi_prod = 26'(cfg_q.freq_ref) * 26'(cfg_q.hi_offset);
    hi_full = hi_prod / PERMILLE;
    lo_prod = 26'(cfg_q.freq_ref) * 26'(cfg_q.lo_offset);
    lo_full = lo_prod / PERMILLE;
    hi_s = hi_active ? signed'(19'(hi_full[15:0])) : '0;
    lo_s = lo_active ? signed'(19'(lo_full[15:0])) : '0;
    center_s = signed'(19'(cfg_q.freq_ref)) + hi_s - lo_s;
  end

  assign traverse = (cfg_q.app_mode == APP_TRAVERSE);

  ramp_stepper #(
    .TENTH_CYCLES_P(TENTH_CYCLES_P)
  ) u_stepper (
    .clk(CLK),
    .rst(RST),
    .run(state_q != ST_BYPASS),
    .restart(state_d != state_q),
    .span(18'(amp_full[15:0]) << 1),
    .time_tenths((state_q == ST_FALL) ? cfg_q.dec_time : cfg_q.acc_time),
    .step(step)
  );

  // swing ramp and output
  always_comb
  begin
    state_d = state_q;
    dev_d = dev_q;
    if (!traverse)
    begin
      state_d = ST_BYPASS;
      dev_d = '0;
    end
    else
    begin
      unique case (state_q)
        ST_BYPASS:
        begin
          state_d = ST_RISE;
          dev_d = '0;
        end
        ST_RISE:
        begin
          if (dev_q >= amp_s)
          begin
            state_d = ST_FALL;
            dev_d = amp_s - scr_s;
          end
          else if (step)
          begin
            dev_d = dev_q + 19'sh00001;
          end
        end
        ST_FALL:
        begin
          if (dev_q <= -amp_s)
          begin
            state_d = ST_RISE;
          end
          else if (step)
          begin
            dev_d = dev_q - 19'sh00001;
          end
        end
      endcase
    end
    sum_s = center_s + dev_q;
    active_d = traverse;
    if (!traverse)
    begin
      out_d = cfg_q.freq_ref;
    end
    else if (sum_s > FREQ_CEIL)
    begin
      out_d = FREQ_CEIL[15:0];
    end
    else if (sum_s < FREQ_FLOOR)
    begin
      out_d = FREQ_FLOOR[15:0];
    end
    else
    begin
      out_d = sum_s[15:0];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_q <= ST_BYPASS;
      dev_q <= '0;
      out_q <= '0;
      active_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      dev_q <= dev_d;
      out_q <= out_d;
      active_q <= active_d;
    end
  end

  assign RDATA = rdata_q;
  assign OUT_FREQ = out_q;
  assign TRAVERSE_ACTIVE = active_q;

  AST_BYPASS_FOLLOWS: assert property (@(posedge CLK) disable iff (RST)
    (!traverse) |=> (OUT_FREQ == $past(cfg_q.freq_ref)) && (state_q == ST_BYPASS))
    else $error("output does not follow reference outside traverse mode");
  AST_PEAK_TURN: assert property (@(posedge CLK) disable iff (RST)
    (traverse && state_q == ST_RISE && dev_q >= amp_s) |=> (state_q == ST_FALL))
    else $error("rise did not turn at swing peak");
  AST_SCRAMBLE_JUMP: assert property (@(posedge CLK) disable iff (RST)
    (traverse && state_q == ST_RISE && dev_q >= amp_s)
    |=> (dev_q == $past(amp_s) - $past(scr_s)))
    else $error("scramble jump size wrong at fall start");
  AST_RISE_STEP: assert property (@(posedge CLK) disable iff (RST)
    (traverse && state_q == ST_RISE && dev_q < amp_s && step) |=> (dev_q == $past(dev_q) + 1))
    else $error("rise ramp did not advance");
  AST_FALL_STEP: assert property (@(posedge CLK) disable iff (RST)
    (traverse && state_q == ST_FALL && dev_q > -amp_s && step) |=> (dev_q == $past(dev_q) - 1))
    else $error("fall ramp did not descend");
  AST_HI_OFFSET: assert property (@(posedge CLK) disable iff (RST)
    (hi_active && !lo_active) |-> (center_s == signed'(19'(cfg_q.freq_ref))
    + signed'(19'(32'(cfg_q.freq_ref) * 32'(cfg_q.hi_offset) / 32'(PERMILLE)))))
    else $error("high offset not added");
  AST_LO_OFFSET: assert property (@(posedge CLK) disable iff (RST)
    (lo_active && !hi_active) |-> (center_s == signed'(19'(cfg_q.freq_ref))
    - signed'(19'(32'(cfg_q.freq_ref) * 32'(cfg_q.lo_offset) / 32'(PERMILLE)))))
    else $error("low offset not subtracted");
endmodule

// ===== verif/terminal_bank.sv
// partner model: digital input terminals of the drive
`timescale 1ns/1ps
module terminal_bank
(
  input wire logic clk,
  input wire logic [7:0] level,
  output logic [7:0] term
);
  // contacts change after the clock edge, like a field switch
  always_ff @(posedge clk)
  begin
    term <= level;
  end
endmodule

// ===== verif/test_traverse_frequency_modulator.sv
// testbench for the traverse frequency modulator
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_traverse_frequency_modulator;
  import traverse_pkg::*;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h00000000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA;
  logic [7:0] TERM_IN;
  logic [7:0] level = 8'h00;
  logic [15:0] OUT_FREQ;
  logic TRAVERSE_ACTIVE;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] rv;

  traverse_modulator #(.TENTH_CYCLES_P(10)) dut (.CLK(CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TERM_IN(TERM_IN),
    .OUT_FREQ(OUT_FREQ), .TRAVERSE_ACTIVE(TRAVERSE_ACTIVE));
  terminal_bank terms (.clk(CLK), .level(level), .term(TERM_IN));

  initial
  begin
    forever #2 CLK = ~CLK;
  end

  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  // defaults and clamping of settings
  task automatic t_defaults();
    rd(REG_AMPLITUDE, rv);
    `CHK(rv, 32'h00000000)
    rd(REG_ACC_TIME, rv);
    `CHK(rv, 32'h00000014)
    rd(REG_DEC_TIME, rv);
    `CHK(rv, 32'h0000001E)
    rd(8'hFC, rv);
    `CHK(rv, 32'h00000000)
    wr(REG_APP_MODE, 32'h00000007);
    rd(REG_APP_MODE, rv);
    `CHK(rv, 32'h00000004)
    `CHK(TRAVERSE_ACTIVE, 1'b0)
    wr(REG_APP_MODE, {29'h0, APP_NONE});
    wr(REG_AMPLITUDE, 32'h0000012C);
    rd(REG_AMPLITUDE, rv);
    `CHK(rv, 32'h000000C8)
    wr(REG_SCRAMBLE, 32'h00000258);
    rd(REG_SCRAMBLE, rv);
    `CHK(rv, 32'h000001F4)
    wr(REG_ACC_TIME, 32'h00000000);
    wr(REG_DEC_TIME, 32'h00001B58);
    rd(REG_ACC_TIME, rv);
    `CHK(rv, 32'h00000001)
    rd(REG_DEC_TIME, rv);
    `CHK(rv, 32'h00001770)
    $display("test defaults done");
  endtask

  // offsets: P1 high, P2 low; ref 1000, 10 percent and 5 percent
  task automatic t_offsets();
    wr(REG_AMPLITUDE, 32'h00000000);
    wr(REG_FREQ_REF, 32'h000003E8);
    wr(REG_HI_OFFSET, 32'h00000064);
    wr(REG_LO_OFFSET, 32'h00000032);
    wr(REG_TERM_FUNC_LO, {16'h0000, FUNC_OFFSET_LO, FUNC_OFFSET_HI});
    level <= 8'h01;
    wait_cyc(8);
    `CHK(OUT_FREQ, 16'h03E8)
    `CHK(TRAVERSE_ACTIVE, 1'b0)
    rd(REG_STATUS, rv);
    `CHK(rv, 32'h000403E8)
    wait_cyc(1);
    `CHK(RDATA, 32'h00000000)
    rd(REG_TERM_FUNC_LO, rv);
    `CHK(rv, 32'h00001B1C)
    wr(REG_APP_MODE, {29'h0, APP_TRAVERSE});
    wait_cyc(8);
    `CHK(TRAVERSE_ACTIVE, 1'b1)
    `CHK(OUT_FREQ, 16'h044C)
    level <= 8'h03;
    wait_cyc(8);
    `CHK(OUT_FREQ, 16'h041A)
    level <= 8'h02;
    wait_cyc(8);
    `CHK(OUT_FREQ, 16'h03B6)
    level <= 8'h00;
    wr(REG_APP_MODE, {29'h0, APP_NONE});
    wait_cyc(4);
    $display("test offsets done");
  endtask

  // swing: A = 200, S = 100, rise 600 cycles, fall pacing 800 cycles per 400
  task automatic t_swing();
    int t;
    int t_jump;
    int t_min;
    int t_top;
    logic [15:0] prev;
    logic [15:0] cur;
    logic [15:0] hi;
    logic [15:0] lo;
    t_jump = -1;
    t_min = -1;
    t_top = -1;
    hi = 16'h0000;
    lo = 16'hFFFF;
    wr(REG_AMPLITUDE, 32'h000000C8);
    wr(REG_SCRAMBLE, 32'h000001F4);
    wr(REG_ACC_TIME, 32'h0000003C);
    wr(REG_DEC_TIME, 32'h00000050);
    wr(REG_APP_MODE, {29'h0, APP_TRAVERSE});
    #1;
    prev = OUT_FREQ;
    for (t = 0; t < 2500; t++)
    begin
      @(posedge CLK);
      #1;
      cur = OUT_FREQ;
      if (cur > hi) hi = cur;
      if (cur < lo) lo = cur;
      if (t_jump < 0 && prev == 16'h04B0 && cur == 16'h044C) t_jump = t;
      if (t_jump >= 0 && t_min < 0 && cur == 16'h0320) t_min = t;
      if (t_min >= 0 && t_top < 0 && cur == 16'h04B0) t_top = t;
      prev = cur;
    end
    `CHK(hi, 16'h04B0)
    `CHK(lo, 16'h0320)
    `CHK(t_jump >= 0, 1'b1)
    `CHK((t_min - t_jump) > 588 && (t_min - t_jump) < 612, 1'b1)
    `CHK((t_top - t_min) > 588 && (t_top - t_min) < 612, 1'b1)
    wr(REG_APP_MODE, {29'h0, APP_NONE});
    wait_cyc(2);
    `CHK(OUT_FREQ, 16'h03E8)
    `CHK(TRAVERSE_ACTIVE, 1'b0)
    $display("test swing done");
  endtask

  initial
  begin
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    t_defaults();
    t_offsets();
    t_swing();
    end_sim();
  end
endmodule
